// >>> bbx_alu.sv
`timescale 1ns/1ps
module bbx_alu
   import bbx_pkg::*;
(
   input bbx_dec_s dec_in,
   input wire logic [DATA_W-1:0] file_val_in,
   input wire logic [DATA_W-1:0] acc_in,
   output bbx_res_s res_out
);

   logic [DATA_W-1:0] bit_mask;

   assign bit_mask = BIT_ONE << dec_in.bsel;

   always_comb begin
      res_out.value = file_val_in;
      res_out.wr_file = 1'b0;
      res_out.wr_acc = 1'b0;
      res_out.upd_zero = 1'b0;
      res_out.skip = 1'b0;
      unique case (dec_in.op)
         OP_BIT_CLEAR: begin
            res_out.value = file_val_in & ~bit_mask;
            res_out.wr_file = 1'b1;
         end
         OP_BIT_SET: begin
            res_out.value = file_val_in | bit_mask;
            res_out.wr_file = 1'b1;
         end
         OP_TEST_SKIP_IF_CLEAR: begin
            res_out.skip = (file_val_in & bit_mask) == DATA_RST;
         end
         OP_TEST_SKIP_IF_SET: begin
            res_out.skip = (file_val_in & bit_mask) != DATA_RST;
         end
         OP_DECREMENT_SKIP_ZERO: begin
            res_out.value = file_val_in - DATA_ONE;
            res_out.skip = res_out.value == DATA_RST;
            res_out.wr_file = dec_in.dest;
            res_out.wr_acc = ~dec_in.dest;
         end
         OP_INCREMENT_SKIP_ZERO: begin
            res_out.value = file_val_in + DATA_ONE;
            res_out.skip = res_out.value == DATA_RST;
            res_out.wr_file = dec_in.dest;
            res_out.wr_acc = ~dec_in.dest;
         end
         OP_INCREMENT: begin
            res_out.value = file_val_in + DATA_ONE;
            res_out.wr_file = dec_in.dest;
            res_out.wr_acc = ~dec_in.dest;
            res_out.upd_zero = 1'b1;
         end
         OP_OR_WITH_LITERAL: begin
            res_out.value = acc_in | dec_in.lit[LIT8_W-1:0];
            res_out.wr_acc = 1'b1;
            res_out.upd_zero = 1'b1;
         end
         OP_OR_WITH_FILE: begin
            res_out.value = acc_in | file_val_in;
            res_out.wr_file = dec_in.dest;
            res_out.wr_acc = ~dec_in.dest;
            res_out.upd_zero = 1'b1;
         end
         default: begin
            res_out.value = file_val_in;
         end
      endcase
      res_out.zero = res_out.value == DATA_RST;
   end

endmodule

// >>> bbx_decode.sv
`timescale 1ns/1ps
module bbx_decode
   import bbx_pkg::*;
(
   input wire logic [INSTR_W-1:0] instr_in,
   output bbx_dec_s dec_out
);

   function automatic logic hit(input logic [INSTR_W-1:0] w,
                                input logic [INSTR_W-1:0] m,
                                input logic [INSTR_W-1:0] c);
      return (w & m) == c;
   endfunction

   always_comb begin
      dec_out.faddr = instr_in[FADDR_LSB +: FADDR_W];
      dec_out.bsel = instr_in[BIT_LSB +: BIT_W];
      dec_out.dest = instr_in[DEST_POS];
      dec_out.lit = instr_in[LIT_LSB +: LIT_W];
      // codes outside the supported subset simply advance the counter
      if (hit(instr_in, MASK_EXACT, CODE_BRW)) begin
         dec_out.op = OP_ACCUMULATOR_RELATIVE_BRANCH;
      end else if (hit(instr_in, MASK_BIT_OP, CODE_BIT_CLEAR)) begin
         dec_out.op = OP_BIT_CLEAR;
      end else if (hit(instr_in, MASK_BIT_OP, CODE_BIT_SET)) begin
         dec_out.op = OP_BIT_SET;
      end else if (hit(instr_in, MASK_BIT_OP, CODE_TEST_CLR)) begin
         dec_out.op = OP_TEST_SKIP_IF_CLEAR;
      end else if (hit(instr_in, MASK_BIT_OP, CODE_TEST_SET)) begin
         dec_out.op = OP_TEST_SKIP_IF_SET;
      end else if (hit(instr_in, MASK_BRA, CODE_BRA)) begin
         dec_out.op = OP_LITERAL_RELATIVE_BRANCH;
      end else if (hit(instr_in, MASK_JUMP, CODE_JUMP)) begin
         dec_out.op = OP_ABSOLUTE_JUMP;
      end else if (hit(instr_in, MASK_BYTE_OP, CODE_DEC_SKIP)) begin
         dec_out.op = OP_DECREMENT_SKIP_ZERO;
      end else if (hit(instr_in, MASK_BYTE_OP, CODE_INC_SKIP)) begin
         dec_out.op = OP_INCREMENT_SKIP_ZERO;
      end else if (hit(instr_in, MASK_BYTE_OP, CODE_INC)) begin
         dec_out.op = OP_INCREMENT;
      end else if (hit(instr_in, MASK_BYTE_OP, CODE_OR_LIT)) begin
         dec_out.op = OP_OR_WITH_LITERAL;
      end else if (hit(instr_in, MASK_BYTE_OP, CODE_OR_FILE)) begin
         dec_out.op = OP_OR_WITH_FILE;
      end else begin
         dec_out.op = OP_NOP;
      end
   end

endmodule

// >>> bbx_exec.sv
`timescale 1ns/1ps
module bbx_exec
   import bbx_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic instr_valid_in,
   input wire logic [INSTR_W-1:0] instr_in,
   input wire logic [PAGE_W-1:0] page_latch_in,
   input wire logic file_wr_en_in,
   input wire logic [FADDR_W-1:0] file_wr_addr_in,
   input wire logic [DATA_W-1:0] file_wr_data_in,
   input wire logic [FADDR_W-1:0] file_rd_addr_in,
   output logic [DATA_W-1:0] file_rd_data_out,
   output logic [DATA_W-1:0] acc_out,
   output logic zero_out,
   output logic [PC_W-1:0] pc_out,
   output logic discard_out
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   bbx_byte_t file_q [FILE_DEPTH];
   bbx_byte_t acc_q;
   logic zero_q;
   bbx_pc_t pc_q;
   bbx_pc_t pc_d;
   logic discard_q;
   logic discard_d;
   bbx_byte_t rd_q;

   bbx_dec_s dec;
   bbx_res_s res;
   bbx_byte_t file_val;
   logic accept;
   logic flow_change;
   bbx_pc_t pc_inc;
   bbx_pc_t bra_target;
   bbx_pc_t brw_target;
   bbx_pc_t jump_target;

   // ------------------------------------------------------------------
   // decode and execute
   // ------------------------------------------------------------------
   bbx_decode u_decode (
      .instr_in(instr_in),
      .dec_out(dec)
   );

   assign file_val = file_q[dec.faddr];

   bbx_alu u_alu (
      .dec_in(dec),
      .file_val_in(file_val),
      .acc_in(acc_q),
      .res_out(res)
   );

   // the slot after a branch or taken skip is burnt as a no-operation
   assign accept = instr_valid_in & ~discard_q;

   assign pc_inc = pc_q + PC_STEP;
   assign bra_target = pc_inc + bbx_pc_t'($signed(dec.lit[BRA_K_W-1:0]));
   assign brw_target = pc_inc + bbx_pc_t'(acc_q);
   assign jump_target = {page_latch_in[PAGE_HI:PAGE_LO], dec.lit[PC_LO_W-1:0]};

   assign flow_change = (dec.op == OP_LITERAL_RELATIVE_BRANCH) ||
                        (dec.op == OP_ACCUMULATOR_RELATIVE_BRANCH) ||
                        (dec.op == OP_ABSOLUTE_JUMP);

   // ------------------------------------------------------------------
   // program counter
   // ------------------------------------------------------------------
   always_comb begin
      pc_d = pc_q;
      if (accept) begin
         unique case (dec.op)
            OP_LITERAL_RELATIVE_BRANCH: begin
               pc_d = bra_target;
            end
            OP_ACCUMULATOR_RELATIVE_BRANCH: begin
               pc_d = brw_target;
            end
            OP_ABSOLUTE_JUMP: begin
               pc_d = jump_target;
            end
            default: begin
               // a taken skip steps over the discarded word right away
               pc_d = res.skip ? pc_q + PC_SKIP_STEP : pc_inc;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pc_q <= PC_RST;
      end else begin
         pc_q <= pc_d;
      end
   end

   // ------------------------------------------------------------------
   // second-cycle no-operation slot
   // ------------------------------------------------------------------
   always_comb begin
      discard_d = discard_q;
      if (instr_valid_in) begin
         discard_d = accept & (flow_change | res.skip);
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         discard_q <= 1'b0;
      end else begin
         discard_q <= discard_d;
      end
   end

   // ------------------------------------------------------------------
   // accumulator and zero flag
   // ------------------------------------------------------------------
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         acc_q <= DATA_RST;
      end else if (accept && res.wr_acc) begin
         acc_q <= res.value;
      end
   end

   // only the plain increment and the two or forms touch the flag
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         zero_q <= 1'b0;
      end else if (accept && res.upd_zero) begin
         zero_q <= res.zero;
      end
   end

   // ------------------------------------------------------------------
   // file register
   // ------------------------------------------------------------------
   // the side load port only writes in slots without an accepted
   // instruction, so execution never races a test preload
   generate
      for (genvar i = 0; i < FILE_DEPTH; i++) begin : g_file
         always_ff @(posedge mclk_in or negedge rstn_in) begin
            if (!rstn_in) begin
               file_q[i] <= DATA_RST;
            end else if (accept && res.wr_file &&
                         dec.faddr == FADDR_W'(i)) begin
               file_q[i] <= res.value;
            end else if (!accept && file_wr_en_in &&
                         file_wr_addr_in == FADDR_W'(i)) begin
               file_q[i] <= file_wr_data_in;
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_q <= DATA_RST;
      end else begin
         rd_q <= file_q[file_rd_addr_in];
      end
   end

   assign file_rd_data_out = rd_q;
   assign acc_out = acc_q;
   assign zero_out = zero_q;
   assign pc_out = pc_q;
   assign discard_out = discard_q;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rstn_in);

   logic [DATA_W-1:0] mask_now;
   assign mask_now = BIT_ONE << dec.bsel;

   chk_bit_clear_result: assert property (
      accept && dec.op == OP_BIT_CLEAR |=>
         file_q[$past(dec.faddr)] == ($past(file_val) & ~$past(mask_now)) &&
         zero_q == $past(zero_q) && acc_q == $past(acc_q))
      else $error("bit clear result wrong");

   chk_bit_set_result: assert property (
      accept && dec.op == OP_BIT_SET |=>
         file_q[$past(dec.faddr)] == ($past(file_val) | $past(mask_now)) &&
         zero_q == $past(zero_q))
      else $error("bit set result wrong");

   chk_test_clear_skip: assert property (
      accept && dec.op == OP_TEST_SKIP_IF_CLEAR |=>
         discard_q == (($past(file_val) & $past(mask_now)) == DATA_RST))
      else $error("skip if clear decision wrong");

   chk_test_set_skip: assert property (
      accept && dec.op == OP_TEST_SKIP_IF_SET |=>
         discard_q == (($past(file_val) & $past(mask_now)) != DATA_RST))
      else $error("skip if set decision wrong");

   chk_discard_slot_idle: assert property (
      discard_q && instr_valid_in |=>
         !discard_q && pc_q == $past(pc_q) && acc_q == $past(acc_q))
      else $error("discarded slot had an effect");

   chk_lit_branch_target: assert property (
      accept && dec.op == OP_LITERAL_RELATIVE_BRANCH |=>
         discard_q && pc_q == $past(bra_target) &&
         pc_q == $past(pc_q) + PC_STEP +
            bbx_pc_t'($signed($past(instr_in[BRA_K_W-1:0]))))
      else $error("literal branch target wrong");

   chk_acc_branch_target: assert property (
      accept && dec.op == OP_ACCUMULATOR_RELATIVE_BRANCH |=>
         discard_q && pc_q == $past(pc_q) + PC_STEP + bbx_pc_t'($past(acc_q)) &&
         zero_q == $past(zero_q))
      else $error("accumulator branch target wrong");

   chk_jump_target: assert property (
      accept && dec.op == OP_ABSOLUTE_JUMP |=>
         discard_q && pc_q[PC_LO_W-1:0] == $past(instr_in[PC_LO_W-1:0]) &&
         pc_q[PC_W-1:PC_LO_W] == $past(page_latch_in[PAGE_HI:PAGE_LO]))
      else $error("jump target wrong");

   chk_dest_to_acc: assert property (
      accept && !dec.dest && (dec.op == OP_INCREMENT || dec.op == OP_OR_WITH_FILE ||
         dec.op == OP_INCREMENT_SKIP_ZERO || dec.op == OP_DECREMENT_SKIP_ZERO) |=>
         acc_q == $past(res.value) && file_q[$past(dec.faddr)] == $past(file_val))
      else $error("destination zero did not steer to accumulator");

   chk_dest_to_file: assert property (
      accept && dec.dest && (dec.op == OP_INCREMENT || dec.op == OP_OR_WITH_FILE ||
         dec.op == OP_INCREMENT_SKIP_ZERO || dec.op == OP_DECREMENT_SKIP_ZERO) |=>
         file_q[$past(dec.faddr)] == $past(res.value) && acc_q == $past(acc_q))
      else $error("destination one did not steer to file");

   chk_dec_skip_zero: assert property (
      accept && dec.op == OP_DECREMENT_SKIP_ZERO |=>
         discard_q == ($past(file_val) == DATA_ONE) && zero_q == $past(zero_q) &&
         $past(res.value) == $past(file_val) - DATA_ONE)
      else $error("decrement skip wrong");

   chk_inc_skip_wrap: assert property (
      accept && dec.op == OP_INCREMENT_SKIP_ZERO |=>
         discard_q == ($past(file_val) == ~DATA_RST) && zero_q == $past(zero_q) &&
         pc_q == $past(pc_q) + ($past(file_val) == ~DATA_RST ? PC_SKIP_STEP : PC_STEP))
      else $error("increment skip wrong");

   chk_or_literal: assert property (
      accept && dec.op == OP_OR_WITH_LITERAL |=>
         acc_q == ($past(acc_q) | $past(instr_in[LIT8_W-1:0])) &&
         zero_q == (acc_q == DATA_RST))
      else $error("or with literal wrong");

   chk_or_file: assert property (
      accept && dec.op == OP_OR_WITH_FILE |=>
         $past(res.value) == ($past(acc_q) | $past(file_val)) &&
         zero_q == ($past(res.value) == DATA_RST))
      else $error("or with file wrong");

   chk_zero_flag_inc: assert property (
      accept && dec.op == OP_INCREMENT |=>
         zero_q == ($past(file_val) == ~DATA_RST))
      else $error("zero flag after increment wrong");

   cov_taken_skip: cover property (
      accept && dec.op == OP_TEST_SKIP_IF_CLEAR && res.skip ##1 discard_q && instr_valid_in);

   cov_back_branch: cover property (
      accept && dec.op == OP_LITERAL_RELATIVE_BRANCH && dec.lit[BRA_K_W-1]);

   cov_inc_wrap: cover property (
      accept && dec.op == OP_INCREMENT_SKIP_ZERO && res.skip && dec.dest);

   cov_or_zero: cover property (
      accept && dec.op == OP_OR_WITH_FILE && res.zero);

endmodule

// >>> bbx_pkg.sv
package bbx_pkg;

   // ------------------------------------------------------------------
   // widths and depths
   // ------------------------------------------------------------------
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int BIT_W = 3;
   localparam int PC_W = 15;
   localparam int LIT_W = 11;
   localparam int BRA_K_W = 9;
   localparam int LIT8_W = 8;
   localparam int FILE_DEPTH = 128;
   localparam int PAGE_W = 7;
   localparam int PAGE_LO = 3;
   localparam int PAGE_HI = 6;
   localparam int PC_LO_W = 11;

   // ------------------------------------------------------------------
   // instruction field positions
   // ------------------------------------------------------------------
   localparam int FADDR_LSB = 0;
   localparam int DEST_POS = 7;
   localparam int BIT_LSB = 7;
   localparam int LIT_LSB = 0;

   // ------------------------------------------------------------------
   // opcode masks and match values
   // ------------------------------------------------------------------
   localparam logic [INSTR_W-1:0] MASK_BIT_OP = 14'h3C00;
   localparam logic [INSTR_W-1:0] MASK_BYTE_OP = 14'h3F00;
   localparam logic [INSTR_W-1:0] MASK_BRA = 14'h3E00;
   localparam logic [INSTR_W-1:0] MASK_JUMP = 14'h3800;
   localparam logic [INSTR_W-1:0] MASK_EXACT = 14'h3FFF;
   localparam logic [INSTR_W-1:0] CODE_BIT_CLEAR = 14'h1000;
   localparam logic [INSTR_W-1:0] CODE_BIT_SET = 14'h1400;
   localparam logic [INSTR_W-1:0] CODE_TEST_CLR = 14'h1800;
   localparam logic [INSTR_W-1:0] CODE_TEST_SET = 14'h1C00;
   localparam logic [INSTR_W-1:0] CODE_DEC_SKIP = 14'h0B00;
   localparam logic [INSTR_W-1:0] CODE_INC_SKIP = 14'h0F00;
   localparam logic [INSTR_W-1:0] CODE_INC = 14'h0A00;
   localparam logic [INSTR_W-1:0] CODE_OR_FILE = 14'h0400;
   localparam logic [INSTR_W-1:0] CODE_OR_LIT = 14'h3800;
   localparam logic [INSTR_W-1:0] CODE_BRA = 14'h3200;
   localparam logic [INSTR_W-1:0] CODE_BRW = 14'h000B;
   localparam logic [INSTR_W-1:0] CODE_JUMP = 14'h2800;

   // ------------------------------------------------------------------
   // reset values and steps
   // ------------------------------------------------------------------
   localparam logic [PC_W-1:0] PC_RST = 15'h0000;
   localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
   localparam logic [PC_W-1:0] PC_SKIP_STEP = 15'h0002;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
   localparam logic [DATA_W-1:0] BIT_ONE = 8'h01;

   typedef logic [PC_W-1:0] bbx_pc_t;
   typedef logic [DATA_W-1:0] bbx_byte_t;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_BIT_CLEAR = 4'h1,
      OP_BIT_SET = 4'h2,
      OP_TEST_SKIP_IF_CLEAR = 4'h3,
      OP_TEST_SKIP_IF_SET = 4'h4,
      OP_LITERAL_RELATIVE_BRANCH = 4'h5,
      OP_ACCUMULATOR_RELATIVE_BRANCH = 4'h6,
      OP_ABSOLUTE_JUMP = 4'h7,
      OP_DECREMENT_SKIP_ZERO = 4'h8,
      OP_INCREMENT_SKIP_ZERO = 4'h9,
      OP_INCREMENT = 4'hA,
      OP_OR_WITH_LITERAL = 4'hB,
      OP_OR_WITH_FILE = 4'hC
   } bbx_op_e;

   typedef struct packed {
      bbx_op_e op;
      logic [FADDR_W-1:0] faddr;
      logic [BIT_W-1:0] bsel;
      logic dest;
      logic [LIT_W-1:0] lit;
   } bbx_dec_s;

   typedef struct packed {
      bbx_byte_t value;
      logic wr_file;
      logic wr_acc;
      logic upd_zero;
      logic zero;
      logic skip;
   } bbx_res_s;

endpackage

// >>> bbx_testbench.sv
`timescale 1ns/1ps
module testbench;
   import bbx_pkg::*;

   // ------------------------------------------------------------------
   // signals
   // ------------------------------------------------------------------
   typedef struct packed {
      bbx_pc_t pc;
      bbx_byte_t acc;
      bbx_byte_t rd;
      logic zero;
      logic disc;
   } bbx_note_s;

   logic mclk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic instr_valid_in = 1'b0;
   logic [INSTR_W-1:0] instr_in = '0;
   logic [PAGE_W-1:0] page_latch_in = '0;
   logic file_wr_en_in = 1'b0;
   logic [FADDR_W-1:0] file_wr_addr_in = '0;
   logic [DATA_W-1:0] file_wr_data_in = '0;
   logic [FADDR_W-1:0] file_rd_addr_in = '0;
   logic [DATA_W-1:0] file_rd_data_out;
   logic [DATA_W-1:0] acc_out;
   logic zero_out;
   logic [PC_W-1:0] pc_out;
   logic discard_out;

   bbx_note_s notes[$];
   bbx_note_s mon_n;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   bbx_byte_t fm[FILE_DEPTH];
   bbx_pc_t m_pc = '0;
   bbx_byte_t m_acc = '0;
   logic m_zero = 1'b0;
   logic m_disc = 1'b0;

   always #5 mclk_in = ~mclk_in;

   bbx_exec i_dut (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .instr_valid_in(instr_valid_in),
      .instr_in(instr_in),
      .page_latch_in(page_latch_in),
      .file_wr_en_in(file_wr_en_in),
      .file_wr_addr_in(file_wr_addr_in),
      .file_wr_data_in(file_wr_data_in),
      .file_rd_addr_in(file_rd_addr_in),
      .file_rd_data_out(file_rd_data_out),
      .acc_out(acc_out),
      .zero_out(zero_out),
      .pc_out(pc_out),
      .discard_out(discard_out)
   );

   // ------------------------------------------------------------------
   // compare and report
   // ------------------------------------------------------------------
   task automatic cmp_pc(input bbx_pc_t got, input bbx_pc_t exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_byte(input bbx_byte_t got, input bbx_byte_t exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      if (num_errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------------
   // driver: one cycle, reference model updated and noted
   // ------------------------------------------------------------------
   task automatic step(input logic v, input int kind, input logic [6:0] f, input logic [2:0] b,
                       input logic d, input logic [10:0] k, input logic we,
                       input logic [6:0] wa, input bbx_byte_t wd, input logic [6:0] pg);
      logic [INSTR_W-1:0] w;
      bbx_byte_t r;
      logic a;
      logic skp;
      bbx_note_s n;
      @(negedge mclk_in);
      n.rd = fm[f];
      a = v && !m_disc;
      skp = 1'b0;
      r = '0;
      if (v && m_disc) m_disc = 1'b0;
      if (a) m_pc = m_pc + PC_STEP;
      case (kind)
         0: begin w = CODE_BIT_CLEAR | {4'h0, b, f}; if (a) fm[f][b] = 1'b0; end
         1: begin w = CODE_BIT_SET | {4'h0, b, f}; if (a) fm[f][b] = 1'b1; end
         2: begin w = CODE_TEST_CLR | {4'h0, b, f}; skp = a && !fm[f][b]; end
         3: begin w = CODE_TEST_SET | {4'h0, b, f}; skp = a && fm[f][b]; end
         4: begin
            w = CODE_BRA | {5'h00, k[8:0]};
            if (a) m_pc = m_pc + {{6{k[8]}}, k[8:0]};
         end
         5: begin w = CODE_BRW; if (a) m_pc = m_pc + {7'h00, m_acc}; end
         6: begin w = CODE_JUMP | {3'h0, k}; if (a) m_pc = {pg[6:3], k}; end
         7: begin w = CODE_DEC_SKIP | {6'h00, d, f}; r = fm[f] - DATA_ONE; end
         8: begin w = CODE_INC_SKIP | {6'h00, d, f}; r = fm[f] + DATA_ONE; end
         9: begin w = CODE_INC | {6'h00, d, f}; r = fm[f] + DATA_ONE; end
         10: begin w = CODE_OR_LIT | {6'h00, k[7:0]}; r = m_acc | k[7:0]; end
         11: begin w = CODE_OR_FILE | {6'h00, d, f}; r = m_acc | fm[f]; end
         default: begin
            // a word outside the subset only steps the counter
            w = '0;
         end
      endcase
      if (a && kind >= 4 && kind <= 6) m_disc = 1'b1;
      if (a && kind >= 7 && kind <= 11) begin
         if (kind != 10 && d) fm[f] = r;
         else m_acc = r;
         if (kind >= 9) m_zero = (r == 8'h00);
         if (kind <= 8) skp = (r == 8'h00);
      end
      if (skp) begin
         m_pc = m_pc + PC_STEP;
         m_disc = 1'b1;
      end
      // a preload that meets an accepted instruction is dropped by the block
      if (we && !a) fm[wa] = wd;
      n.pc = m_pc;
      n.acc = m_acc;
      n.zero = m_zero;
      n.disc = m_disc;
      notes.push_back(n);
      instr_valid_in = v;
      instr_in = w;
      page_latch_in = pg;
      file_wr_en_in = we;
      file_wr_addr_in = wa;
      file_wr_data_in = wd;
      file_rd_addr_in = f;
   endtask

   function automatic bbx_byte_t pick_byte();
      case ($urandom_range(3))
         0: return 8'h00;
         1: return 8'h01;
         2: return 8'hFF;
         default: return bbx_byte_t'($urandom);
      endcase
   endfunction

   // ------------------------------------------------------------------
   // monitor: outputs settle shortly after each rising edge
   // ------------------------------------------------------------------
   always @(posedge mclk_in) begin
      #2;
      if (notes.size() > 0) begin
         mon_n = notes.pop_front();
         cmp_pc(pc_out, mon_n.pc);
         cmp_byte(acc_out, mon_n.acc);
         cmp_byte(file_rd_data_out, mon_n.rd);
         cmp_bit(zero_out, mon_n.zero);
         cmp_bit(discard_out, mon_n.disc);
      end
   end

   // a hang is cut short well past the expected run of about 900 cycles
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      int seed;
      seed = $urandom(32'hC00F52CD);
      for (int i = 0; i < FILE_DEPTH; i++) fm[i] = 8'h00;
      repeat (5) @(negedge mclk_in);
      cmp_pc(pc_out, PC_RST);
      cmp_byte(acc_out, DATA_RST);
      cmp_bit(discard_out, 1'b0);
      rstn_in = 1'b1;
      // wrap to zero skips, then a decrement back from zero does not
      step(1'b0, 9, 7'h03, 3'h0, 1'b0, 11'h000, 1'b1, 7'h03, 8'hFF, 7'h00);
      step(1'b1, 8, 7'h03, 3'h0, 1'b1, 11'h000, 1'b0, 7'h00, 8'h00, 7'h00);
      step(1'b1, 9, 7'h03, 3'h0, 1'b1, 11'h000, 1'b0, 7'h00, 8'h00, 7'h00);
      step(1'b1, 7, 7'h03, 3'h0, 1'b0, 11'h000, 1'b1, 7'h04, 8'h01, 7'h00);
      step(1'b1, 7, 7'h04, 3'h0, 1'b1, 11'h000, 1'b0, 7'h00, 8'h00, 7'h00);
      step(1'b0, 0, 7'h04, 3'h0, 1'b0, 11'h000, 1'b0, 7'h00, 8'h00, 7'h00);
      step(1'b1, 10, 7'h04, 3'h0, 1'b0, 11'h000, 1'b0, 7'h00, 8'h00, 7'h00);
      for (int i = 0; i < 900; i++) begin
         step($urandom_range(7) != 0, $urandom_range(12), 7'($urandom_range(7)),
              3'($urandom), 1'($urandom), 11'($urandom), $urandom_range(4) == 0,
              7'($urandom_range(7)), pick_byte(), 7'($urandom));
      end
      step(1'b0, 0, 7'h00, 3'h0, 1'b0, 11'h000, 1'b0, 7'h00, 8'h00, 7'h00);
      repeat (3) @(negedge mclk_in);
      // a reset in mid-run clears the file, both flags and the counter
      rstn_in = 1'b0;
      for (int i = 0; i < FILE_DEPTH; i++) fm[i] = 8'h00;
      m_pc = PC_RST;
      m_acc = DATA_RST;
      m_zero = 1'b0;
      m_disc = 1'b0;
      repeat (2) @(negedge mclk_in);
      cmp_pc(pc_out, PC_RST);
      cmp_byte(file_rd_data_out, DATA_RST);
      cmp_bit(zero_out, 1'b0);
      cmp_bit(discard_out, 1'b0);
      rstn_in = 1'b1;
      step(1'b1, 10, 7'h00, 3'h0, 1'b0, 11'h000, 1'b0, 7'h00, 8'h00, 7'h00);
      step(1'b1, 9, 7'h05, 3'h0, 1'b1, 11'h000, 1'b0, 7'h00, 8'h00, 7'h00);
      step(1'b0, 0, 7'h05, 3'h0, 1'b0, 11'h000, 1'b0, 7'h00, 8'h00, 7'h00);
      repeat (3) @(negedge mclk_in);
      wrap_up();
   end

endmodule
